// ===== rwc_frame_keep.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_frame_keep (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to top
  rwc_link_if.keep lnk
);
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WOKE} rwc_keep_st_t;

  rwc_keep_st_t st, next_st;
  logic         store, next_store;
  logic         drop, next_drop;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_store = 1'b0;
    next_drop  = 1'b0;
    unique case (st)
      ST_RUN: begin
        next_store = lnk.frame_end && lnk.frame_ok;
        if (lnk.deep) begin
          next_st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (lnk.frame_end && lnk.frame_ok && lnk.wake_frame) begin
          next_store = lnk.keep_trig;
          next_drop  = !lnk.keep_trig;
          next_st    = ST_WOKE;
        end else if (lnk.wake_other) begin
          next_st = ST_WOKE;
        end else if (lnk.frame_end) begin
          next_drop = 1'b1;
        end
      end
      ST_WOKE: begin
        next_store = lnk.frame_end && lnk.frame_ok;
      end
    endcase
    if (!lnk.deep) begin
      next_st    = ST_RUN;
      next_store = lnk.frame_end && lnk.frame_ok;
      next_drop  = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st    <= ST_RUN;
      store <= 1'b0;
      drop  <= 1'b0;
    end else begin
      st    <= next_st;
      store <= next_store;
      drop  <= next_drop;
    end
  end

  assign lnk.store = store;
  assign lnk.drop  = drop;
endmodule // rwc_frame_keep
`default_nettype wire

// ===== rwc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rwc_link_if;
  // timer group
  logic        eee_en;
  logic        rm_en;
  logic [31:0] req_dly;
  logic [23:0] rm_dly;
  logic        fifo_empty;
  logic        tx_lpi;
  logic        tx_exit;
  // frame storing group
  logic        keep_trig;
  logic        deep;
  logic        wake_frame;
  logic        wake_other;
  logic        frame_end;
  logic        frame_ok;
  logic        store;
  logic        drop;
  modport top (output eee_en, rm_en, req_dly, rm_dly, fifo_empty, keep_trig, deep,
               wake_frame, wake_other, frame_end, frame_ok,
               input tx_lpi, tx_exit, store, drop);
  modport tmr (input eee_en, rm_en, req_dly, rm_dly, fifo_empty,
               output tx_lpi, tx_exit);
  modport keep (input keep_trig, deep, wake_frame, wake_other, frame_end, frame_ok,
                output store, drop);
endinterface
`default_nettype wire

// ===== rwc_lpi_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_lpi_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to top
  rwc_link_if.tmr  lnk
);
  typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_LPI} rwc_tmr_st_t;
  localparam int PW = $clog2(rwc_pkg::US_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(rwc_pkg::US_CYCLES - 1);

  rwc_tmr_st_t st, next_st;
  logic [PW-1:0] pre, next_pre;
  logic [31:0]   us, next_us;
  logic          lpi, next_lpi;
  logic          ext, next_ext;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_st  = st;
    next_lpi = lpi;
    next_ext = 1'b0;
    next_pre = (pre == PRE_LAST) ? '0 : pre + 1'b1;
    next_us  = (pre == PRE_LAST) ? us + 32'h1 : us;
    unique case (st)
      ST_WAIT: begin
        next_pre = '0;
        next_us  = '0;
        next_lpi = 1'b0;
        if (lnk.fifo_empty) begin
          next_st = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!lnk.fifo_empty) begin
          next_st = ST_WAIT;
        end else if (us >= lnk.req_dly) begin
          next_st  = ST_LPI;
          next_lpi = 1'b1;
          next_pre = '0;
          next_us  = '0;
        end
      end
      ST_LPI: begin
        if (!lnk.fifo_empty) begin
          next_st  = ST_WAIT;
          next_lpi = 1'b0;
        end else if (lnk.rm_en && us >= {8'h00, lnk.rm_dly}) begin
          next_st  = ST_WAIT;
          next_lpi = 1'b0;
          next_ext = 1'b1;
        end
      end
    endcase
    if (!lnk.eee_en) begin
      next_st  = ST_WAIT;
      next_lpi = 1'b0;
      next_ext = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st  <= ST_WAIT;
      pre <= '0;
      us  <= '0;
      lpi <= 1'b0;
      ext <= 1'b0;
    end else begin
      st  <= next_st;
      pre <= next_pre;
      us  <= next_us;
      lpi <= next_lpi;
      ext <= next_ext;
    end
  end

  assign lnk.tx_lpi  = lpi;
  assign lnk.tx_exit = ext;
endmodule // rwc_lpi_timer
`default_nettype wire

// ===== rwc_pkg.sv
`default_nettype none
package rwc_pkg;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [11:0] REQ_DLY_OFS = 12'h130;
  localparam logic [11:0] RM_DLY_OFS  = 12'h138;
  localparam logic [11:0] WAKE_OFS    = 12'h140;
  localparam logic [11:0] CTRL_OFS    = 12'h14c;
  // --------------------------------------------------------------
  // wake register field positions
  // --------------------------------------------------------------
  localparam int FE_EN_BIT  = 14;
  localparam int TX_FL_BIT  = 13;
  localparam int TX_EN_BIT  = 12;
  localparam int RX_FL_BIT  = 11;
  localparam int RX_EN_BIT  = 10;
  localparam int FE_FL_BIT  = 9;
  localparam int KEEP_BIT   = 8;
  localparam int ADR_FL_BIT = 7;
  localparam int PAT_FL_BIT = 6;
  // --------------------------------------------------------------
  // control register field positions
  // --------------------------------------------------------------
  localparam int CLR_EN_BIT = 0;
  localparam int CLR_FL_BIT = 1;
  localparam int EEE_BIT    = 2;
  localparam int RM_EN_BIT  = 3;
  // --------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------
  localparam logic [31:0] REQ_DLY_RST = 32'h00000000;
  localparam logic [23:0] RM_DLY_RST  = 24'h000000;
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam int CLK_NS    = 10;
  localparam int US_NS     = 1000;
  localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ===== rwc_top.sv
// What this block does
// - filter-engine enable lets a good filtered frame request wakeup; resets 0.
// - enables 14, 12, 10 clear on resume done when resume-clears-enables set.
// - flags 13, 11, 9, 7 clear on resume done when resume-clears-flags set.
// - tx exit flag sets on timed low power exit; write one clears.
// - tx exit flag never sets while its enable is clear.
// - both low power exit flags held zero while energy efficiency off.
// - tx exit enable makes tx low power exit a wake source; resets 0.
// - rx exit flag sets on rx wake signalling; write one clears.
// - rx exit flag never sets while its enable is clear.
// - rx exit enable makes rx wake signalling a wake source; resets 0.
// - filter-engine flag sets on every good frame passing the filters.
// - keep option stores trigger frame and all later good frames.
// - keep option clear drops trigger frame, stores later good frames.
// - wake not caused by frame stores all later good frames.
// - keep option acts only in the frame storing suspend state.
// - address match flag sets on valid frame to station address.
// - pattern flag sets on valid frame matching the wakeup pattern.
// - after tx fifo empties wait programmed delay, restart if refilled.
// - auto removal expiry ends tx low power idle and sets tx flag if tx exit enable set.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rwc_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output var  logic [31:0]       dat_o,
  output var  logic              ack_o,
  // mac events
  input  wire logic              tx_fifo_empty_i,
  input  wire logic              rx_lpi_exit_i,
  input  wire logic              rx_frame_end_i,
  input  wire logic              rx_frame_good_i,
  input  wire logic              rx_filter_pass_i,
  input  wire logic              rx_addr_match_i,
  input  wire logic              rx_pattern_match_i,
  input  wire logic              other_wake_i,
  // suspend sequencer
  input  wire logic              deep_suspend_i,
  input  wire logic              resume_done_i,
  output var  logic              wake_request_o,
  // datapath controls
  output wire logic              tx_lpi_o,
  output wire logic              frame_store_o,
  output wire logic              frame_drop_o
);
  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (ADDR_W < 9) begin : g_bad_addr
    $error("rwc_top: ADDR_W too small for register map");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic        fe_en, next_fe_en;
  logic        tx_en, next_tx_en;
  logic        rx_en, next_rx_en;
  logic        keep, next_keep;
  logic        tx_fl, next_tx_fl;
  logic        rx_fl, next_rx_fl;
  logic        fe_fl, next_fe_fl;
  logic        adr_fl, next_adr_fl;
  logic        pat_fl, next_pat_fl;
  logic [3:0]  ctrl, next_ctrl;
  logic [31:0] req_dly, next_req_dly;
  logic [23:0] rm_dly, next_rm_dly;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_wake_req;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [11:0] ofs;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [31:0] wake_word;
  logic        wr_wake;
  logic        eee_on;

  assign req     = cyc_i && stb_i && !ack_o;
  assign wr      = req && we_i;
  assign ofs     = {{(12 - 9){1'b0}}, adr_i[8:0]};
  assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr_wake = wr && ofs == rwc_pkg::WAKE_OFS;
  assign eee_on  = ctrl[rwc_pkg::EEE_BIT];

  // --------------------------------------------------------------
  // read view
  // --------------------------------------------------------------
  always_comb begin
    wake_word = 32'h00000000;
    wake_word[rwc_pkg::FE_EN_BIT]  = fe_en;
    wake_word[rwc_pkg::TX_FL_BIT]  = tx_fl;
    wake_word[rwc_pkg::TX_EN_BIT]  = tx_en;
    wake_word[rwc_pkg::RX_FL_BIT]  = rx_fl;
    wake_word[rwc_pkg::RX_EN_BIT]  = rx_en;
    wake_word[rwc_pkg::FE_FL_BIT]  = fe_fl;
    wake_word[rwc_pkg::KEEP_BIT]   = keep;
    wake_word[rwc_pkg::ADR_FL_BIT] = adr_fl;
    wake_word[rwc_pkg::PAT_FL_BIT] = pat_fl;
  end

  always_comb begin
    unique case (ofs)
      rwc_pkg::WAKE_OFS:    rdata = wake_word;
      rwc_pkg::REQ_DLY_OFS: rdata = req_dly;
      rwc_pkg::RM_DLY_OFS:  rdata = {8'h00, rm_dly};
      rwc_pkg::CTRL_OFS:    rdata = {28'h0000000, ctrl};
      default:              rdata = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------
  rwc_link_if lnk ();

  logic fe_set;
  logic tx_set;
  logic rx_set;
  logic adr_set;
  logic pat_set;
  logic good_end;

  assign good_end = rx_frame_end_i && rx_frame_good_i;
  assign fe_set   = good_end && rx_filter_pass_i;
  assign tx_set   = lnk.tx_exit && tx_en && eee_on;
  assign rx_set   = rx_lpi_exit_i && rx_en && eee_on;
  assign adr_set  = good_end && rx_addr_match_i;
  assign pat_set  = good_end && rx_pattern_match_i;

  assign lnk.eee_en     = eee_on;
  assign lnk.rm_en      = ctrl[rwc_pkg::RM_EN_BIT];
  assign lnk.req_dly    = req_dly;
  assign lnk.rm_dly     = rm_dly;
  assign lnk.fifo_empty = tx_fifo_empty_i;
  assign lnk.keep_trig  = keep;
  assign lnk.deep       = deep_suspend_i;
  assign lnk.wake_frame = fe_set && fe_en;
  assign lnk.wake_other = tx_set || rx_set || other_wake_i;
  assign lnk.frame_end  = rx_frame_end_i;
  assign lnk.frame_ok   = fe_set;

  rwc_lpi_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lnk   (lnk.tmr)
  );

  rwc_frame_keep u_keep (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lnk   (lnk.keep)
  );

  assign tx_lpi_o      = lnk.tx_lpi;
  assign frame_store_o = lnk.store;
  assign frame_drop_o  = lnk.drop;

  // --------------------------------------------------------------
  // next values
  // --------------------------------------------------------------
  logic clr_en;
  logic clr_fl;

  assign clr_en = resume_done_i && ctrl[rwc_pkg::CLR_EN_BIT];
  assign clr_fl = resume_done_i && ctrl[rwc_pkg::CLR_FL_BIT];

  always_comb begin
    next_ack = req;
    next_dat = (req && !we_i) ? rdata : 32'h00000000;
    // plain read/write fields
    next_fe_en = fe_en;
    next_tx_en = tx_en;
    next_rx_en = rx_en;
    next_keep  = keep;
    if (wr_wake && wmask[rwc_pkg::FE_EN_BIT]) begin
      next_fe_en = dat_i[rwc_pkg::FE_EN_BIT];
    end
    if (wr_wake && wmask[rwc_pkg::TX_EN_BIT]) begin
      next_tx_en = dat_i[rwc_pkg::TX_EN_BIT];
    end
    if (wr_wake && wmask[rwc_pkg::RX_EN_BIT]) begin
      next_rx_en = dat_i[rwc_pkg::RX_EN_BIT];
    end
    if (wr_wake && wmask[rwc_pkg::KEEP_BIT]) begin
      next_keep = dat_i[rwc_pkg::KEEP_BIT];
    end
    if (clr_en) begin
      next_fe_en = 1'b0;
      next_tx_en = 1'b0;
      next_rx_en = 1'b0;
    end
    // write-one-clear flags, a set in the same cycle wins
    next_tx_fl = tx_fl;
    next_rx_fl = rx_fl;
    next_fe_fl = fe_fl;
    next_adr_fl = adr_fl;
    next_pat_fl = pat_fl;
    if (wr_wake && wmask[rwc_pkg::TX_FL_BIT] && dat_i[rwc_pkg::TX_FL_BIT]) begin
      next_tx_fl = 1'b0;
    end
    if (wr_wake && wmask[rwc_pkg::RX_FL_BIT] && dat_i[rwc_pkg::RX_FL_BIT]) begin
      next_rx_fl = 1'b0;
    end
    if (wr_wake && wmask[rwc_pkg::FE_FL_BIT] && dat_i[rwc_pkg::FE_FL_BIT]) begin
      next_fe_fl = 1'b0;
    end
    if (wr_wake && wmask[rwc_pkg::ADR_FL_BIT] && dat_i[rwc_pkg::ADR_FL_BIT]) begin
      next_adr_fl = 1'b0;
    end
    if (wr_wake && wmask[rwc_pkg::PAT_FL_BIT] && dat_i[rwc_pkg::PAT_FL_BIT]) begin
      next_pat_fl = 1'b0;
    end
    if (clr_fl) begin
      next_tx_fl  = 1'b0;
      next_rx_fl  = 1'b0;
      next_fe_fl  = 1'b0;
      next_adr_fl = 1'b0;
    end
    if (tx_set) begin
      next_tx_fl = 1'b1;
    end
    if (rx_set) begin
      next_rx_fl = 1'b1;
    end
    if (fe_set) begin
      next_fe_fl = 1'b1;
    end
    if (adr_set) begin
      next_adr_fl = 1'b1;
    end
    if (pat_set) begin
      next_pat_fl = 1'b1;
    end
    if (!eee_on) begin
      next_tx_fl = 1'b0;
      next_rx_fl = 1'b0;
    end
    // wakeup request pulse
    next_wake_req = (fe_set && fe_en)
                 || tx_set
                 || rx_set;
    // own registers
    next_ctrl    = ctrl;
    next_req_dly = req_dly;
    next_rm_dly  = rm_dly;
    if (wr && ofs == rwc_pkg::CTRL_OFS) begin
      next_ctrl = (ctrl & ~wmask[3:0]) | (dat_i[3:0] & wmask[3:0]);
    end
    if (wr && ofs == rwc_pkg::REQ_DLY_OFS) begin
      next_req_dly = (req_dly & ~wmask) | (dat_i & wmask);
    end
    if (wr && ofs == rwc_pkg::RM_DLY_OFS) begin
      next_rm_dly = (rm_dly & ~wmask[23:0]) | (dat_i[23:0] & wmask[23:0]);
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_en          <= 1'b0;
      tx_en          <= 1'b0;
      rx_en          <= 1'b0;
      keep           <= 1'b0;
      tx_fl          <= 1'b0;
      rx_fl          <= 1'b0;
      fe_fl          <= 1'b0;
      adr_fl         <= 1'b0;
      pat_fl         <= 1'b0;
      ctrl           <= rwc_pkg::CTRL_RST;
      req_dly        <= rwc_pkg::REQ_DLY_RST;
      rm_dly         <= rwc_pkg::RM_DLY_RST;
      ack_o          <= 1'b0;
      dat_o          <= 32'h00000000;
      wake_request_o <= 1'b0;
    end else begin
      fe_en          <= next_fe_en;
      tx_en          <= next_tx_en;
      rx_en          <= next_rx_en;
      keep           <= next_keep;
      tx_fl          <= next_tx_fl;
      rx_fl          <= next_rx_fl;
      fe_fl          <= next_fe_fl;
      adr_fl         <= next_adr_fl;
      pat_fl         <= next_pat_fl;
      ctrl           <= next_ctrl;
      req_dly        <= next_req_dly;
      rm_dly         <= next_rm_dly;
      ack_o          <= next_ack;
      dat_o          <= next_dat;
      wake_request_o <= next_wake_req;
    end
  end
endmodule // rwc_top
`default_nettype wire

// ===== rwc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module rwc_top_props #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // wishbone
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // events and outputs
  input wire logic              tx_fifo_empty_i,
  input wire logic              rx_lpi_exit_i,
  input wire logic              rx_frame_end_i,
  input wire logic              rx_frame_good_i,
  input wire logic              rx_filter_pass_i,
  input wire logic              deep_suspend_i,
  input wire logic              wake_request_o,
  input wire logic              tx_lpi_o,
  input wire logic              frame_store_o,
  input wire logic              frame_drop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic       eee_m;
  logic       next_eee_m;
  logic       lpi_q;
  logic       next_lpi_q;
  logic [3:0] cause_q;
  logic [3:0] next_cause_q;
  logic       good;
  always_comb begin
    good = rx_frame_end_i && rx_frame_good_i && rx_filter_pass_i;
    next_eee_m = eee_m;
    if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
        && adr_i == ADDR_W'(rwc_pkg::CTRL_OFS)) begin
      next_eee_m = dat_i[rwc_pkg::EEE_BIT];
    end
    next_lpi_q = tx_lpi_o;
    next_cause_q = {cause_q[2:0], rx_lpi_exit_i || (lpi_q && !tx_lpi_o) || good};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eee_m <= 1'b0;
      lpi_q <= 1'b0;
      cause_q <= 4'h0;
    end else begin
      eee_m <= next_eee_m;
      lpi_q <= next_lpi_q;
      cause_q <= next_cause_q;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ack_next; (cyc_i && stb_i && !ack_o) |=> ack_o; endproperty
  property p_ack_once; ack_o |=> !ack_o; endproperty
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  property p_rsvd_zero; ack_o |-> dat_o[31:15] == 17'h0; endproperty
  property p_eee_off;
    (ack_o && !we_i && adr_i == ADDR_W'(rwc_pkg::WAKE_OFS) && !eee_m)
      |-> dat_o[13] == 1'b0 && dat_o[11] == 1'b0;
  endproperty
  property p_store_normal; (good && !deep_suspend_i) |=> frame_store_o; endproperty
  property p_bad_kept_out;
    (rx_frame_end_i && !(rx_frame_good_i && rx_filter_pass_i)) |=> !frame_store_o;
  endproperty
  property p_out_cause;
    (frame_store_o || frame_drop_o) |-> $past(rx_frame_end_i) && !(frame_store_o && frame_drop_o);
  endproperty
  property p_lpi_leave; !tx_fifo_empty_i |=> !tx_lpi_o; endproperty
  property p_wake_cause; wake_request_o |-> cause_q != 4'h0; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");
  a_eee_off: assert property (p_eee_off) else $error("exit flag with eee off");
  a_store_normal: assert property (p_store_normal) else $error("frame not stored");
  a_bad_kept_out: assert property (p_bad_kept_out) else $error("bad frame stored");
  a_out_cause: assert property (p_out_cause) else $error("store or drop w/o frame");
  a_lpi_leave: assert property (p_lpi_leave) else $error("lpi held with data");
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
  c_wake: cover property (wake_request_o);
  c_drop: cover property (frame_drop_o);
  c_store: cover property (frame_store_o);
  c_lpi_exit: cover property ($fell(tx_lpi_o));
endmodule // rwc_top_props
bind rwc_top rwc_top_props #(.ADDR_W(ADDR_W)) rwc_top_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .tx_fifo_empty_i(tx_fifo_empty_i), .rx_lpi_exit_i(rx_lpi_exit_i),
  .rx_frame_end_i(rx_frame_end_i), .rx_frame_good_i(rx_frame_good_i),
  .rx_filter_pass_i(rx_filter_pass_i), .deep_suspend_i(deep_suspend_i),
  .wake_request_o(wake_request_o), .tx_lpi_o(tx_lpi_o),
  .frame_store_o(frame_store_o), .frame_drop_o(frame_drop_o));
`default_nettype wire

// ===== tb_rwc_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("Error %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_rwc_top;
  localparam logic [11:0] WAKE = rwc_pkg::WAKE_OFS;
  localparam logic [11:0] CTRL = rwc_pkg::CTRL_OFS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        fifo_e = 1'b0;
  logic [2:0]  evt = 3'h0;
  logic [3:0]  frm = 4'h0;
  logic        fend = 1'b0;
  logic        deep = 1'b0;
  logic        wreq;
  logic        lpi;
  logic        fst;
  logic        fdr;
  logic [7:0]  wake_cnt = 8'h00;
  logic [7:0]  store_cnt = 8'h00;
  logic [7:0]  drop_cnt = 8'h00;
  logic [31:0] q;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n;
  rwc_top rwc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_fifo_empty_i(fifo_e), .rx_lpi_exit_i(evt[0]), .rx_frame_end_i(fend),
    .rx_frame_good_i(frm[3]), .rx_filter_pass_i(frm[2]), .rx_addr_match_i(frm[1]),
    .rx_pattern_match_i(frm[0]), .other_wake_i(evt[1]), .deep_suspend_i(deep),
    .resume_done_i(evt[2]), .wake_request_o(wreq), .tx_lpi_o(lpi),
    .frame_store_o(fst), .frame_drop_o(fdr));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= 3'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic frame(input logic [3:0] f);
    @(posedge clk_i);
    fend <= 1'b1;
    frm <= f;
    @(posedge clk_i);
    fend <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wait_lpi(input logic v, input int lo, input int hi);
    n = 0;
    while (lpi !== v && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK((n >= lo && n <= hi), 1'b1)
  endtask
  // ----------------------------------------------------------------
  // monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (wreq === 1'b1) wake_cnt <= wake_cnt + 8'h01;
    if (fst === 1'b1) store_cnt <= store_cnt + 8'h01;
    if (fdr === 1'b1) drop_cnt <= drop_cnt + 8'h01;
    if (cycles == 6000) begin
      err_count++;
      $display("Error %0t: timeout", $time);
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(WAKE, 32'h0);
    rd(12'h130, 32'h0);
    wr(WAKE, 32'hffffffff);
    rd(WAKE, 32'h00005500);
    rd(12'h1fc, 32'h0);
    frame(4'hf);
    rd(WAKE, 32'h000057c0);
    wr(WAKE, 32'h000057c0);
    frame(4'h4);
    frame(4'ha);
    rd(WAKE, 32'h00005580);
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h010100)
    pulse(3'b001);
    rd(WAKE, 32'h00005580);
    wr(CTRL, 32'h4);
    pulse(3'b001);
    rd(WAKE, 32'h00005d80);
    wr(CTRL, 32'h0);
    rd(WAKE, 32'h00005580);
    wr(CTRL, 32'h4);
    wr(WAKE, 32'h00005980);
    pulse(3'b001);
    rd(WAKE, 32'h00005100);
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h020100)
    wr(12'h130, 32'h1);
    wr(12'h138, 32'h2);
    rd(12'h138, 32'h2);
    wr(WAKE, 32'h00005500);
    wr(CTRL, 32'hc);
    fifo_e <= 1'b1;
    wait_lpi(1'b1, 95, 210);
    wait_lpi(1'b0, 195, 310);
    rd(WAKE, 32'h00007500);
    wr(WAKE, 32'h00006500);
    wait_lpi(1'b1, 80, 210);
    wait_lpi(1'b0, 195, 310);
    fifo_e <= 1'b0;
    rd(WAKE, 32'h00004500);
    repeat (150) @(posedge clk_i);
    `CHK(lpi, 1'b0)
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h030100)
    wr(CTRL, 32'h4);
    wr(WAKE, 32'h00005500);
    frame(4'hf);
    pulse(3'b001);
    pulse(3'b100);
    rd(WAKE, 32'h00005fc0);
    wr(CTRL, 32'h7);
    pulse(3'b100);
    rd(WAKE, 32'h00000140);
    wr(WAKE, 32'h00004040);
    deep <= 1'b1;
    frame(4'hc);
    frame(4'hc);
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h070301)
    deep <= 1'b0;
    wr(WAKE, 32'h00004100);
    deep <= 1'b1;
    frame(4'hc);
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h080401)
    deep <= 1'b0;
    wr(WAKE, 32'h0);
    deep <= 1'b1;
    pulse(3'b010);
    frame(4'hc);
    `CHK(({wake_cnt, store_cnt, drop_cnt}), 24'h080501)
    finish_test();
  end
endmodule // tb_rwc_top
`default_nettype wire
